// File: logic/t8c_pkg.sv
// Constants, register map and types of the 8-bit timer/counter compare unit
//
// Function
// - Clock select zero gives no timer tick; counter holds.
// - Each tick clears, increments or decrements the counter per mode and direction.
// - Software reads and writes the count value at any time.
// - A software count write beats any same-cycle clear or count.
// - Three-bit waveform field: two bits in control A, one in control B.
// - Overflow flag set where the mode says; it can request an interrupt.
// - Two 8-bit equality comparators against count value, always running.
// - A match sets its compare flag on the following timer tick.
// - Enabled flag requests interrupt; cleared by service or writing one.
// - PWM modes double buffer compares, updated at top/bottom; others unbuffered.
// - Buffered: software reaches buffer; otherwise the active compare value.
// - Force strobe in non-PWM acts like a match on state only.
// - A count write blocks all matches on the next timer tick.
// - Compare states keep their values across waveform mode changes.
// - Compare output mode is unbuffered and acts on the next match.
// - Compare output mode selects set, clear or toggle on match.
// - Reset forces both compare states to zero.
// - Nonzero output mode replaces port data; direction bit still rules.
// - Output mode zero leaves compare state unchanged on a match.
// - Mode zero counts up, wraps 0xFF to 0x00, overflow same tick.
// - Mode two clears the counter on a channel A match.
// - Bottom is 0x00, max 0xFF, top is max or channel A compare.
`default_nettype none
package t8c_pkg;
  // Register byte offsets
  localparam logic [7:0] T8C_OFS_COUNT = 8'h00;
  localparam logic [7:0] T8C_OFS_CMPA = 8'h04;
  localparam logic [7:0] T8C_OFS_CMPB = 8'h08;
  localparam logic [7:0] T8C_OFS_CTLA = 8'h0C;
  localparam logic [7:0] T8C_OFS_CTLB = 8'h10;
  localparam logic [7:0] T8C_OFS_FLAG = 8'h14;
  localparam logic [7:0] T8C_OFS_IEN = 8'h18;
  localparam logic [7:0] T8C_OFS_PORT = 8'h1C;
  // Field positions
  localparam int T8C_CTLA_WGM_LO = 0;
  localparam int T8C_CTLA_COMB_LO = 4;
  localparam int T8C_CTLA_COMA_LO = 6;
  localparam int T8C_CTLB_CS_LO = 0;
  localparam int T8C_CTLB_WGM2 = 3;
  localparam int T8C_CTLB_FRCB = 6;
  localparam int T8C_CTLB_FRCA = 7;
  localparam int T8C_FLG_OVF = 0;
  localparam int T8C_FLG_CMPA = 1;
  localparam int T8C_FLG_CMPB = 2;
  localparam int T8C_PORT_DATA_LO = 0;
  localparam int T8C_PORT_DIR_LO = 2;
  // Count limits and reset values
  localparam logic [7:0] T8C_BOTTOM = 8'h00;
  localparam logic [7:0] T8C_MAX = 8'hFF;
  localparam logic [7:0] T8C_RST_BYTE = 8'h00;
  localparam logic [2:0] T8C_CS_STOP = 3'h0;
  // Waveform modes
  typedef enum logic [2:0] {
    T8C_WGM_NORMAL = 3'b000,
    T8C_WGM_PC_MAX = 3'b001,
    T8C_WGM_CTC = 3'b010,
    T8C_WGM_FAST_MAX = 3'b011,
    T8C_WGM_RSV4 = 3'b100,
    T8C_WGM_PC_CMP = 3'b101,
    T8C_WGM_RSV6 = 3'b110,
    T8C_WGM_FAST_CMP = 3'b111
  } t8c_wgm_t;
  // Compare output actions
  localparam logic [1:0] T8C_COM_OFF = 2'h0;
  localparam logic [1:0] T8C_COM_TGL = 2'h1;
  localparam logic [1:0] T8C_COM_CLR = 2'h2;
  localparam logic [1:0] T8C_COM_SET = 2'h3;
  // Captured AHB address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
  } t8c_aphase_t;
endpackage
`default_nettype wire

// File: logic/t8c_timer.sv
// 8-bit timer/counter with two compare channels behind an AHB-Lite slave
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`default_nettype none
module t8c_timer
  import t8c_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic timer_tick,
  input wire logic [2:0] irq_ack,
  output logic irq_ovf,
  output logic irq_cmp_a,
  output logic irq_cmp_b,
  output logic [2:0] clock_select_field,
  output logic oc_pin_a,
  output logic oc_pin_b,
  output logic oc_oe_n_a,
  output logic oc_oe_n_b
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // PWM modes are the odd codes; reserved codes behave as normal mode
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = m[0];
  endfunction

  // Non-PWM action, shared by real matches and force strobes
  function automatic logic act_np(input logic oc, input logic [1:0] com);
    case (com)
      T8C_COM_TGL: act_np = ~oc;
      T8C_COM_CLR: act_np = 1'b0;
      T8C_COM_SET: act_np = 1'b1;
      default: act_np = oc;
    endcase
  endfunction

  // Next compare state for one channel
  function automatic logic oc_step(input logic oc, input logic [1:0] com, input logic [2:0] m,
                                   input logic evt, input logic wrap, input logic up,
                                   input logic frc, input logic chan_a);
    logic r;
    r = oc;
    if (!is_pwm(m)) begin
      if (evt || frc) begin
        r = act_np(oc, com);
      end
    end else if (com == T8C_COM_TGL) begin
      if (evt && chan_a && m[2]) begin
        r = ~oc;
      end
    end else if (com != T8C_COM_OFF) begin
      if (evt) begin
        if (m[1]) begin
          r = (com == T8C_COM_SET);
        end else begin
          r = up ? (com == T8C_COM_SET) : (com == T8C_COM_CLR);
        end
      end
      if (wrap && m[1]) begin
        r = (com == T8C_COM_CLR);
      end
    end
    oc_step = r;
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************

  t8c_aphase_t ap_ff, nxt_ap;
  logic rd_pend_ff, nxt_rd_pend;
  logic hready_ff, nxt_hready;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [31:0] rd_word;

  // Reads take one wait state so that a write just before lands first
  always_comb begin
    nxt_ap = '0;
    nxt_rd_pend = 1'b0;
    nxt_hready = 1'b1;
    nxt_hrdata = hrdata_ff;
    if (rd_pend_ff) begin
      nxt_hrdata = rd_word;
    end else if (hsel && htrans[1] && hready) begin
      nxt_ap.wr = hwrite;
      nxt_ap.rd = ~hwrite;
      nxt_ap.addr = haddr[7:0];
      nxt_rd_pend = ~hwrite;
      nxt_hready = hwrite;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ap_ff <= '0;
      rd_pend_ff <= 1'b0;
      hready_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      ap_ff <= nxt_ap;
      rd_pend_ff <= nxt_rd_pend;
      hready_ff <= nxt_hready;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hreadyout = hready_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;

  // Data-phase write strobes
  logic wr_cnt, wr_cmpa, wr_cmpb, wr_ctla, wr_ctlb, wr_flag, wr_ien, wr_port;
  assign wr_cnt = ap_ff.wr && (ap_ff.addr == T8C_OFS_COUNT);
  assign wr_cmpa = ap_ff.wr && (ap_ff.addr == T8C_OFS_CMPA);
  assign wr_cmpb = ap_ff.wr && (ap_ff.addr == T8C_OFS_CMPB);
  assign wr_ctla = ap_ff.wr && (ap_ff.addr == T8C_OFS_CTLA);
  assign wr_ctlb = ap_ff.wr && (ap_ff.addr == T8C_OFS_CTLB);
  assign wr_flag = ap_ff.wr && (ap_ff.addr == T8C_OFS_FLAG);
  assign wr_ien = ap_ff.wr && (ap_ff.addr == T8C_OFS_IEN);
  assign wr_port = ap_ff.wr && (ap_ff.addr == T8C_OFS_PORT);

  // ****************************************
  // Timer state
  // ****************************************

  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] cmpa_ff, nxt_cmpa, cmpb_ff, nxt_cmpb;
  logic [7:0] bufa_ff, nxt_bufa, bufb_ff, nxt_bufb;
  logic [7:0] ctla_ff, nxt_ctla;
  logic [4:0] ctlb_ff, nxt_ctlb;
  logic [2:0] flag_ff, nxt_flag, ien_ff, nxt_ien;
  logic [3:0] port_ff, nxt_port;
  logic up_ff, nxt_up, block_ff, nxt_block;
  logic oca_ff, nxt_oca, ocb_ff, nxt_ocb;
  logic pina_ff, pinb_ff, oena_ff, oenb_ff;
  logic [2:0] irq_ff;

  logic [2:0] wgm;
  logic [1:0] com_a, com_b;
  logic tick, pwm, match_a, match_b, evt_a, evt_b, frc_a, frc_b;
  logic [7:0] top_val;

  assign wgm = {ctlb_ff[T8C_CTLB_WGM2], ctla_ff[T8C_CTLA_WGM_LO +: 2]};
  assign com_a = ctla_ff[T8C_CTLA_COMA_LO +: 2];
  assign com_b = ctla_ff[T8C_CTLA_COMB_LO +: 2];
  assign pwm = is_pwm(wgm);
  // Ticks are dropped while the clock select is zero
  assign tick = timer_tick && (ctlb_ff[T8C_CTLB_CS_LO +: 3] != T8C_CS_STOP);
  // Top is the channel A compare in modes 5 and 7, else max
  assign top_val = (wgm[2] && wgm[0]) ? cmpa_ff : T8C_MAX;
  // Comparators run every cycle
  assign match_a = (cnt_ff == cmpa_ff);
  assign match_b = (cnt_ff == cmpb_ff);
  // Matches only count on a tick that is not blocked by a count write
  assign evt_a = tick && match_a && !block_ff;
  assign evt_b = tick && match_b && !block_ff;
  assign frc_a = wr_ctlb && hwdata[T8C_CTLB_FRCA] && !pwm;
  assign frc_b = wr_ctlb && hwdata[T8C_CTLB_FRCB] && !pwm;

  // Counter, buffers, flags and compare states
  always_comb begin
    logic ovf;
    logic wrap;
    logic upd;
    ovf = 1'b0;
    wrap = 1'b0;
    upd = 1'b0;
    nxt_cnt = cnt_ff;
    nxt_up = up_ff;
    if (tick) begin
      case (wgm)
        T8C_WGM_CTC: begin
          nxt_cnt = match_a ? T8C_BOTTOM : cnt_ff + 8'h01;
          ovf = !match_a && (cnt_ff == T8C_MAX);
        end
        T8C_WGM_FAST_MAX, T8C_WGM_FAST_CMP: begin
          wrap = (cnt_ff == top_val);
          nxt_cnt = wrap ? T8C_BOTTOM : cnt_ff + 8'h01;
          ovf = wrap;
          upd = wrap;
        end
        T8C_WGM_PC_MAX, T8C_WGM_PC_CMP: begin
          if (up_ff) begin
            upd = (cnt_ff == top_val);
            nxt_up = !upd;
            nxt_cnt = upd ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
          end else begin
            ovf = (cnt_ff == T8C_BOTTOM);
            nxt_up = ovf;
            nxt_cnt = ovf ? cnt_ff + 8'h01 : cnt_ff - 8'h01;
          end
        end
        default: begin
          // Normal mode: plain up count with wrap
          nxt_cnt = cnt_ff + 8'h01;
          ovf = (cnt_ff == T8C_MAX);
        end
      endcase
    end
    if (!pwm) begin
      nxt_up = 1'b1;
    end
    if (wr_cnt) begin
      nxt_cnt = hwdata[7:0];
    end
    // Block clears on the next timer_tick pulse, even while the clock select is zero
    nxt_block = wr_cnt ? 1'b1 : (timer_tick ? 1'b0 : block_ff);
    // Buffered writes land in the buffer; otherwise both copies
    nxt_bufa = wr_cmpa ? hwdata[7:0] : bufa_ff;
    nxt_bufb = wr_cmpb ? hwdata[7:0] : bufb_ff;
    nxt_cmpa = cmpa_ff;
    nxt_cmpb = cmpb_ff;
    if (!pwm) begin
      nxt_cmpa = nxt_bufa;
      nxt_cmpb = nxt_bufb;
    end else if (upd) begin
      nxt_cmpa = bufa_ff;
      nxt_cmpb = bufb_ff;
    end
    nxt_ctla = wr_ctla ? hwdata[7:0] : ctla_ff;
    nxt_ctlb = wr_ctlb ? hwdata[4:0] : ctlb_ff;
    nxt_ien = wr_ien ? hwdata[2:0] : ien_ff;
    nxt_port = wr_port ? hwdata[3:0] : port_ff;
    // Set beats clear for write-one and service acknowledge
    nxt_flag = flag_ff & ~(irq_ack | (wr_flag ? hwdata[2:0] : 3'h0));
    nxt_flag[T8C_FLG_OVF] = nxt_flag[T8C_FLG_OVF] | ovf;
    nxt_flag[T8C_FLG_CMPA] = nxt_flag[T8C_FLG_CMPA] | evt_a;
    nxt_flag[T8C_FLG_CMPB] = nxt_flag[T8C_FLG_CMPB] | evt_b;
    // Mode changes never touch the compare states
    nxt_oca = oc_step(oca_ff, com_a, wgm, evt_a, wrap, up_ff, frc_a, 1'b1);
    nxt_ocb = oc_step(ocb_ff, com_b, wgm, evt_b, wrap, up_ff, frc_b, 1'b0);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= T8C_RST_BYTE;
      cmpa_ff <= T8C_RST_BYTE;
      cmpb_ff <= T8C_RST_BYTE;
      bufa_ff <= T8C_RST_BYTE;
      bufb_ff <= T8C_RST_BYTE;
      ctla_ff <= T8C_RST_BYTE;
      ctlb_ff <= 5'h00;
      flag_ff <= 3'h0;
      ien_ff <= 3'h0;
      port_ff <= 4'h0;
      up_ff <= 1'b1;
      block_ff <= 1'b0;
      oca_ff <= 1'b0;
      ocb_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      cmpa_ff <= nxt_cmpa;
      cmpb_ff <= nxt_cmpb;
      bufa_ff <= nxt_bufa;
      bufb_ff <= nxt_bufb;
      ctla_ff <= nxt_ctla;
      ctlb_ff <= nxt_ctlb;
      flag_ff <= nxt_flag;
      ien_ff <= nxt_ien;
      port_ff <= nxt_port;
      up_ff <= nxt_up;
      block_ff <= nxt_block;
      oca_ff <= nxt_oca;
      ocb_ff <= nxt_ocb;
    end
  end

  // ****************************************
  // Pins, interrupts and read mux
  // ****************************************

  // Outputs are registered from next values, so they track without lag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pina_ff <= 1'b0;
      pinb_ff <= 1'b0;
      oena_ff <= 1'b1;
      oenb_ff <= 1'b1;
      irq_ff <= 3'h0;
    end else begin
      pina_ff <= (nxt_ctla[T8C_CTLA_COMA_LO +: 2] != T8C_COM_OFF) ? nxt_oca
                                                       : nxt_port[T8C_PORT_DATA_LO];
      pinb_ff <= (nxt_ctla[T8C_CTLA_COMB_LO +: 2] != T8C_COM_OFF) ? nxt_ocb
                                                       : nxt_port[T8C_PORT_DATA_LO + 1];
      oena_ff <= ~nxt_port[T8C_PORT_DIR_LO];
      oenb_ff <= ~nxt_port[T8C_PORT_DIR_LO + 1];
      irq_ff <= nxt_flag & nxt_ien;
    end
  end

  assign oc_pin_a = pina_ff;
  assign oc_pin_b = pinb_ff;
  assign oc_oe_n_a = oena_ff;
  assign oc_oe_n_b = oenb_ff;
  assign irq_ovf = irq_ff[T8C_FLG_OVF];
  assign irq_cmp_a = irq_ff[T8C_FLG_CMPA];
  assign irq_cmp_b = irq_ff[T8C_FLG_CMPB];
  assign clock_select_field = ctlb_ff[T8C_CTLB_CS_LO +: 3];

  // Force strobes always read back as zero; unmapped reads give zero
  always_comb begin
    case (ap_ff.addr)
      T8C_OFS_COUNT: rd_word = {24'h000000, cnt_ff};
      T8C_OFS_CMPA: rd_word = {24'h000000, bufa_ff};
      T8C_OFS_CMPB: rd_word = {24'h000000, bufb_ff};
      T8C_OFS_CTLA: rd_word = {24'h000000, ctla_ff};
      T8C_OFS_CTLB: rd_word = {27'h0000000, ctlb_ff};
      T8C_OFS_FLAG: rd_word = {29'h00000000, flag_ff};
      T8C_OFS_IEN: rd_word = {29'h00000000, ien_ff};
      T8C_OFS_PORT: rd_word = {28'h0000000, port_ff};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_stop_hold;
    (clock_select_field == T8C_CS_STOP && !wr_cnt) |=> (cnt_ff == $past(cnt_ff));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

  property p_write_wins;
    wr_cnt |=> (cnt_ff == $past(hwdata[7:0]));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");

  property p_flag_next;
    (tick && match_a && !block_ff) |=> flag_ff[T8C_FLG_CMPA];
  endproperty
  a_flag_next: assert property (p_flag_next) else $error("compare flag A not set");

  property p_block;
    wr_cnt ##1 timer_tick |-> !evt_a && !evt_b;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after write");

  property p_normal_wrap;
    (tick && wgm == T8C_WGM_NORMAL && cnt_ff == T8C_MAX && !wr_cnt)
      |=> (cnt_ff == T8C_BOTTOM) && flag_ff[T8C_FLG_OVF];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_ctc_clear;
    (tick && wgm == T8C_WGM_CTC && match_a && !wr_cnt) |=> (cnt_ff == T8C_BOTTOM);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear on match A");

  property p_com_off;
    (com_a == T8C_COM_OFF) |=> (oca_ff == $past(oca_ff));
  endproperty
  a_com_off: assert property (p_com_off) else $error("state changed with mode off");

  property p_force;
    (frc_a && com_a == T8C_COM_TGL && !evt_a) |=> (oca_ff != $past(oca_ff))
      && (flag_ff[T8C_FLG_CMPA] == $past(flag_ff[T8C_FLG_CMPA]));
  endproperty
  a_force: assert property (p_force) else $error("force strobe misbehaved");

  property p_pin_override;
    // Pin and state are registered from the same next values, so no lag
    (com_a != T8C_COM_OFF) |-> (oc_pin_a == oca_ff);
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin not compare state");

  c_ctc_match: cover property (tick && wgm == T8C_WGM_CTC && match_a);
  c_pc_turn: cover property (tick && pwm && !wgm[1] && !up_ff ##[1:600] tick && up_ff);
  c_force: cover property (frc_b);
  c_read: cover property (rd_pend_ff ##1 hreadyout);

endmodule
`default_nettype wire

// File: bench/t8c_cpu_model.sv
// CPU model that services the timer's interrupt requests
`default_nettype none
module t8c_cpu_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_ovf,
  input wire logic irq_cmp_a,
  input wire logic irq_cmp_b,
  input wire logic svc_en,
  input wire logic [3:0] svc_delay,
  output logic [2:0] irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pick;
  // Highest priority pending request, overflow first
  always_comb begin
    pick = irq_ovf ? 3'h1 : (irq_cmp_a ? 3'h2 : (irq_cmp_b ? 3'h4 : 3'h0));
  end
  // Latency is set by the bench, which draws one random delay for the single serviced overflow
  initial begin
    irq_ack = 3'h0;
    forever begin
      @(posedge mclk);
      if (svc_en && rst_n && (pick != 3'h0)) begin
        repeat (svc_delay) @(posedge mclk);
        irq_ack <= pick;
        @(posedge mclk);
        irq_ack <= 3'h0;
        @(posedge mclk);
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/t8c_timer_test.sv
// Self-checking bench of the 8-bit timer/counter compare unit
`default_nettype none
module t8c_timer_test
  import t8c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'b0;
  logic rst_n, hsel, hwrite, hready, hreadyout, hresp, timer_tick, svc_en;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_ack, clock_select_field;
  logic irq_ovf, irq_cmp_a, irq_cmp_b, oc_pin_a, oc_pin_b, oc_oe_n_a, oc_oe_n_b;
  logic [3:0] svc_delay;
  logic [1:0] cm_tbl [4] = '{T8C_COM_SET, T8C_COM_OFF, T8C_COM_TGL, T8C_COM_CLR};
  int mismatches, n_checks;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // 20 MHz clock
  always #25 mclk = ~mclk;
  t8c_timer t8c_timer_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timer_tick(timer_tick),
    .irq_ack(irq_ack), .irq_ovf(irq_ovf), .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b),
    .clock_select_field(clock_select_field), .oc_pin_a(oc_pin_a), .oc_pin_b(oc_pin_b),
    .oc_oe_n_a(oc_oe_n_a), .oc_oe_n_b(oc_oe_n_b));
  t8c_cpu_model t8c_cpu_model_i (.mclk(mclk), .rst_n(rst_n), .irq_ovf(irq_ovf),
    .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .svc_en(svc_en),
    .svc_delay(svc_delay), .irq_ack(irq_ack));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Compare state after a match under a given output mode
  function automatic logic oc_after(input logic [1:0] cm, input logic st);
    case (cm)
      T8C_COM_SET: return 1'b1;
      T8C_COM_CLR: return 1'b0;
      T8C_COM_TGL: return ~st;
      default: return st;
    endcase
  endfunction
  function automatic logic exp_pin(input logic [1:0] cm, input logic st, input logic dat);
    return (cm != T8C_COM_OFF) ? st : dat;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Single AHB transfer; tk raises a timer tick during the data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic tk, output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h00000000;
    timer_tick <= tk;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    timer_tick <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 1'b0, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 1'b0, q);
    chk(q & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
      @(posedge mclk);
      timer_tick <= 1'b0;
    end
  endtask
  // Set both output modes and force a match on both channels
  task automatic frc(input logic [1:0] cm, input logic [1:0] wgm);
    wr(T8C_OFS_CTLA, {24'h000000, cm, cm, 2'h0, wgm});
    wr(T8C_OFS_CTLB, 32'h000000C0);
    repeat (3) @(negedge mclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Watchdog far beyond the expected several hundred cycles
  initial begin
    #(20000 * 50);
    mismatches++;
    stop_test();
  end
  initial begin
    logic [7:0] c0, r;
    logic [31:0] q;
    logic [2:0] cs;
    logic [1:0] cm;
    logic sa, sb;
    int n;
    mismatches = 0;
    n_checks = 0;
    seed = 32'h00008937;
    {rst_n, hsel, hwrite, timer_tick, svc_en} = 5'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    svc_delay = 4'h3;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // All registers and one unmapped slot read zero; pins idle
    for (int a = 0; a <= 32; a += 4) begin
      rdchk(8'(a), 32'hFFFFFFFF, 32'h00000000);
    end
    chk({hresp, oc_pin_a, oc_pin_b, oc_oe_n_a, oc_oe_n_b}, 5'h03);
    // Random start and bursts; a stopped clock select freezes the count
    for (int k = 0; k < 6; k++) begin
      c0 = 8'(xs());
      cs = k[0] ? (3'(xs()) | 3'h1) : T8C_CS_STOP;
      n = 2 + int'(xs() & 32'h7);
      wr(T8C_OFS_CTLB, {29'h0, cs});
      @(negedge mclk);
      chk(clock_select_field, cs);
      wr(T8C_OFS_COUNT, {24'h0, c0});
      tick(n);
      rdchk(T8C_OFS_COUNT, 32'hFF, {24'h0, (cs != 3'h0) ? c0 + 8'(n) : c0});
    end
    // Software write lands on the same edge as a tick
    wr(T8C_OFS_CTLB, 32'h00000001);
    bus(1'b1, T8C_OFS_COUNT, 32'h000000A5, 1'b1, q);
    rdchk(T8C_OFS_COUNT, 32'hFF, 32'h000000A5);
    // Wrap from the maximum in normal mode
    wr(T8C_OFS_IEN, 32'h00000001);
    wr(T8C_OFS_COUNT, 32'h000000FE);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(1);
    rdchk(T8C_OFS_FLAG, 32'h1, 32'h0);
    tick(1);
    @(negedge mclk);
    chk(irq_ovf, 1'b1);
    rdchk(T8C_OFS_COUNT, 32'hFF, 32'h0);
    rdchk(T8C_OFS_FLAG, 32'h1, 32'h1);
    wr(T8C_OFS_FLAG, 32'h00000001);
    rdchk(T8C_OFS_FLAG, 32'h1, 32'h0);
    // Overflow serviced by the CPU model after a random latency
    svc_delay <= 4'(xs());
    svc_en <= 1'b1;
    wr(T8C_OFS_COUNT, 32'h000000FF);
    tick(1);
    repeat (24) @(posedge mclk);
    rdchk(T8C_OFS_FLAG, 32'h1, 32'h0);
    chk(irq_ovf, 1'b0);
    svc_en <= 1'b0;
    // Count written equal to compare: that match is swallowed
    wr(T8C_OFS_IEN, 32'h00000007);
    wr(T8C_OFS_CMPA, 32'h00000010);
    wr(T8C_OFS_COUNT, 32'h00000010);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(1);
    rdchk(T8C_OFS_FLAG, 32'h2, 32'h0);
    wr(T8C_OFS_COUNT, 32'h0000000F);
    tick(1);
    rdchk(T8C_OFS_FLAG, 32'h2, 32'h0);
    tick(1);
    rdchk(T8C_OFS_FLAG, 32'h2, 32'h2);
    chk({irq_cmp_a, irq_cmp_b}, 2'h2);
    // Clear on match with a random top
    r = (8'(xs()) & 8'h1F) | 8'h01;
    wr(T8C_OFS_CTLA, 32'(T8C_WGM_CTC));
    wr(T8C_OFS_CMPA, {24'h0, r});
    wr(T8C_OFS_COUNT, 32'h00000000);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(int'(r) + 1);
    rdchk(T8C_OFS_COUNT, 32'hFF, 32'h0);
    rdchk(T8C_OFS_FLAG, 32'h3, 32'h2);
    // Set the compare state before the pins become outputs
    wr(T8C_OFS_PORT, 32'h00000002);
    frc(T8C_COM_CLR, 2'h0);
    sa = 1'b0;
    sb = 1'b0;
    wr(T8C_OFS_PORT, 32'h0000000E);
    @(negedge mclk);
    chk({oc_oe_n_a, oc_oe_n_b}, 2'h0);
    wr(T8C_OFS_FLAG, 32'h00000007);
    // Forced matches under every output mode, switching waveform modes between
    for (int k = 0; k < 10; k++) begin
      cm = (k < 4) ? cm_tbl[k] : 2'(xs());
      frc(cm, k[0] ? 2'h2 : 2'h0);
      sa = oc_after(cm, sa);
      sb = oc_after(cm, sb);
      chk({oc_pin_a, oc_pin_b}, {exp_pin(cm, sa, 1'b0), exp_pin(cm, sb, 1'b1)});
    end
    rdchk(T8C_OFS_FLAG, 32'h6, 32'h0);
    // Buffered compare in fast mode waits for the wrap
    wr(T8C_OFS_CTLA, 32'h00000000);
    wr(T8C_OFS_CMPB, 32'h00000040);
    wr(T8C_OFS_CTLA, 32'(T8C_WGM_FAST_MAX));
    wr(T8C_OFS_CTLB, 32'h00000001);
    wr(T8C_OFS_CMPB, 32'h00000022);
    rdchk(T8C_OFS_CMPB, 32'hFF, 32'h22);
    wr(T8C_OFS_COUNT, 32'h00000021);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(2);
    rdchk(T8C_OFS_FLAG, 32'h4, 32'h0);
    wr(T8C_OFS_COUNT, 32'h000000FE);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(37);
    rdchk(T8C_OFS_FLAG, 32'h4, 32'h4);
    chk(irq_cmp_b, 1'b1);
    // Phase correct turns down at the maximum and overflows at the bottom
    wr(T8C_OFS_CTLA, 32'(T8C_WGM_PC_MAX));
    wr(T8C_OFS_COUNT, 32'h000000FE);
    tick(3);
    rdchk(T8C_OFS_COUNT, 32'hFF, 32'hFD);
    // Not the bottom value, since the count turns up at the bottom
    wr(T8C_OFS_COUNT, 32'h00000002);
    wr(T8C_OFS_FLAG, 32'h00000007);
    tick(3);
    rdchk(T8C_OFS_COUNT, 32'hFF, 32'h01);
    rdchk(T8C_OFS_FLAG, 32'h1, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
